// >>> hdl/quasi_bidir_port_pair.sv
// Purpose: Two 8-bit quasi-bidirectional ports with alternate functions
// Assumes: Pins resolved outside; weak pullup is external to these signals
// Notes: Output enable is active low; strong-high pulse follows a 0-to-1 write
// Functional notes
// - Two eight-pin ports, GPIO or alternate function
// - Per-pin memory or GPIO select by config
// - Reset sets all latches, weak pullup only
// - Latch one is input; pin level reported
// - Writing zero holds strong pulldown
// - Zero-to-one write pulses strong high driver
// - Memory mode bits 0-3 are chip enables
// - Memory mode bits 4-7 are address 16-19
// - CAN port bit0 transmit, bit1 receive
// - CAN port bit2 receive, bit3 transmit
// - Relocate bit moves second serial transmit to bit3; receive is always read from bit2
// - CAN port bits 4-7 peripheral enables
`timescale 1ns/1ns
module quasi_bidir_port_pair (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic [qport_pkg::PORT_W-1:0] i_mem_wr_data,
	input wire logic i_mem_wr,
	input wire logic [qport_pkg::PORT_W-1:0] i_can_wr_data,
	input wire logic i_can_wr,
	input wire logic [qport_pkg::PORT_W-1:0] i_mem_port_function_config,
	input wire logic [3:0] i_prog_chip_enable,
	input wire logic [3:0] i_upper_addr,
	input wire logic i_can_enable,
	input wire logic i_can_first_transmit,
	input wire logic i_can_second_transmit,
	input wire logic i_serial1_pin_relocate,
	input wire logic i_serial_second_transmit,
	input wire logic [3:0] i_periph_enable_sel,
	input wire logic [3:0] i_periph_enable,
	input wire logic [qport_pkg::PORT_W-1:0] i_mem_pin,
	input wire logic [qport_pkg::PORT_W-1:0] i_can_pin,
	output logic [qport_pkg::PORT_W-1:0] o_mem_pin,
	output logic [qport_pkg::PORT_W-1:0] o_mem_pin_oe_n,
	output logic [qport_pkg::PORT_W-1:0] o_can_pin,
	output logic [qport_pkg::PORT_W-1:0] o_can_pin_oe_n,
	output logic [qport_pkg::PORT_W-1:0] o_mem_rd_data,
	output logic [qport_pkg::PORT_W-1:0] o_can_rd_data,
	output logic o_can_first_receive,
	output logic o_can_second_receive,
	output logic o_serial_second_receive
);
	import qport_pkg::*;

	typedef struct packed {
		logic [PORT_W-1:0] mem_latch;
		logic [PORT_W-1:0] can_latch;
		logic [PORT_W*BOOST_W-1:0] mem_boost;
		logic [PORT_W*BOOST_W-1:0] can_boost;
		logic [PORT_W-1:0] mem_pin;
		logic [PORT_W-1:0] mem_oe_n;
		logic [PORT_W-1:0] can_pin;
		logic [PORT_W-1:0] can_oe_n;
		logic [PORT_W-1:0] mem_rd;
		logic [PORT_W-1:0] can_rd;
		logic can0_rx;
		logic can1_rx;
		logic ser1_rx;
	} state_t;

	state_t s_q;
	state_t s_d;

	// ****************************************
	// Alternate function select, memory-capable port
	// ****************************************
	logic [PORT_W-1:0] mem_alt;
	logic [PORT_W-1:0] mem_alt_v;

	assign mem_alt[MEM_CE_LO +: MEM_CE_N] = i_prog_chip_enable;
	assign mem_alt[MEM_ADDR_LO +: MEM_ADDR_N] = i_upper_addr;
	assign mem_alt_v = i_mem_port_function_config;

	// ****************************************
	// Alternate function select, CAN-capable port
	// ****************************************
	logic [PORT_W-1:0] can_alt;
	logic [PORT_W-1:0] can_alt_v;

	assign can_alt[CAN0_TX_BIT] = i_can_first_transmit;
	assign can_alt_v[CAN0_TX_BIT] = i_can_enable;
	// Receive pins get no alternate drive; they follow their latch bit, so the far side can drive them only while that bit is one
	assign can_alt[CAN0_RX_BIT] = 1'b0;
	assign can_alt_v[CAN0_RX_BIT] = 1'b0;
	assign can_alt[CAN1_RX_BIT] = 1'b0;
	assign can_alt_v[CAN1_RX_BIT] = 1'b0;
	// Serial relocation wins over the second CAN transmit
	assign can_alt[CAN1_TX_BIT] = i_serial1_pin_relocate ? i_serial_second_transmit :
		i_can_second_transmit;
	assign can_alt_v[CAN1_TX_BIT] = i_can_enable || i_serial1_pin_relocate;
	assign can_alt[PCE_LO +: PCE_N] = i_periph_enable;
	assign can_alt_v[PCE_LO +: PCE_N] = i_periph_enable_sel;

	// ****************************************
	// Per-pin latch and driver cells
	// ****************************************
	logic [PORT_W-1:0] mem_latch_d;
	logic [PORT_W*BOOST_W-1:0] mem_boost_d;
	logic [PORT_W-1:0] mem_pin_d;
	logic [PORT_W-1:0] mem_oe_n_d;
	logic [PORT_W-1:0] can_latch_d;
	logic [PORT_W*BOOST_W-1:0] can_boost_d;
	logic [PORT_W-1:0] can_pin_d;
	logic [PORT_W-1:0] can_oe_n_d;

	for (genvar g = 0; g < PORT_W; g++) begin : g_pin
		qport_pin_cell #(
			.BW(BOOST_W)
		) mem_cell_u (
			.i_wr(i_mem_wr),
			.i_wr_bit(i_mem_wr_data[g]),
			.i_latch_q(s_q.mem_latch[g]),
			.i_boost_q(s_q.mem_boost[BOOST_W*g +: BOOST_W]),
			.i_boost_load(BOOST_LOAD),
			.i_alt_v(mem_alt_v[g]),
			.i_alt_bit(mem_alt[g]),
			.o_latch_d(mem_latch_d[g]),
			.o_boost_d(mem_boost_d[BOOST_W*g +: BOOST_W]),
			.o_pin_d(mem_pin_d[g]),
			.o_oe_n_d(mem_oe_n_d[g])
		);
		qport_pin_cell #(
			.BW(BOOST_W)
		) can_cell_u (
			.i_wr(i_can_wr),
			.i_wr_bit(i_can_wr_data[g]),
			.i_latch_q(s_q.can_latch[g]),
			.i_boost_q(s_q.can_boost[BOOST_W*g +: BOOST_W]),
			.i_boost_load(BOOST_LOAD),
			.i_alt_v(can_alt_v[g]),
			.i_alt_bit(can_alt[g]),
			.o_latch_d(can_latch_d[g]),
			.o_boost_d(can_boost_d[BOOST_W*g +: BOOST_W]),
			.o_pin_d(can_pin_d[g]),
			.o_oe_n_d(can_oe_n_d[g])
		);
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		s_d = s_q;
		s_d.mem_latch = mem_latch_d;
		s_d.mem_boost = mem_boost_d;
		s_d.mem_pin = mem_pin_d;
		s_d.mem_oe_n = mem_oe_n_d;
		s_d.can_latch = can_latch_d;
		s_d.can_boost = can_boost_d;
		s_d.can_pin = can_pin_d;
		s_d.can_oe_n = can_oe_n_d;
		s_d.mem_rd = i_mem_pin;
		s_d.can_rd = i_can_pin;
		s_d.can0_rx = i_can_pin[CAN0_RX_BIT];
		s_d.can1_rx = i_can_pin[CAN1_RX_BIT];
		s_d.ser1_rx = i_can_pin[CAN1_RX_BIT];
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			s_q <= '0;
			s_q.mem_latch <= LATCH_RST;
			s_q.can_latch <= LATCH_RST;
			s_q.mem_pin <= LATCH_RST;
			s_q.can_pin <= LATCH_RST;
			s_q.mem_oe_n <= LATCH_RST;
			s_q.can_oe_n <= LATCH_RST;
			s_q.can0_rx <= 1'b1;
			s_q.can1_rx <= 1'b1;
			s_q.ser1_rx <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_mem_pin = s_q.mem_pin;
	assign o_mem_pin_oe_n = s_q.mem_oe_n;
	assign o_can_pin = s_q.can_pin;
	assign o_can_pin_oe_n = s_q.can_oe_n;
	assign o_mem_rd_data = s_q.mem_rd;
	assign o_can_rd_data = s_q.can_rd;
	assign o_can_first_receive = s_q.can0_rx;
	assign o_can_second_receive = s_q.can1_rx;
	assign o_serial_second_receive = s_q.ser1_rx;
endmodule

// ****************************************
// Per-pin latch, transition driver and output select
// ****************************************
module qport_pin_cell #(
	parameter int BW = 2
) (
	input wire logic i_wr,
	input wire logic i_wr_bit,
	input wire logic i_latch_q,
	input wire logic [BW-1:0] i_boost_q,
	input wire logic [BW-1:0] i_boost_load,
	input wire logic i_alt_v,
	input wire logic i_alt_bit,
	output logic o_latch_d,
	output logic [BW-1:0] o_boost_d,
	output logic o_pin_d,
	output logic o_oe_n_d
);
	always_comb begin
		o_latch_d = i_wr ? i_wr_bit : i_latch_q;
		// Only a zero-to-one latch change starts the strong high pulse
		if (i_wr && i_wr_bit && !i_latch_q) begin
			o_boost_d = i_boost_load;
		end else if (i_boost_q != BW'(0)) begin
			o_boost_d = i_boost_q - BW'(1);
		end else begin
			o_boost_d = i_boost_q;
		end
		// Alternate functions drive both levels strongly
		if (i_alt_v) begin
			o_pin_d = i_alt_bit;
			o_oe_n_d = 1'b0;
		end else begin
			o_pin_d = o_latch_d;
			o_oe_n_d = o_latch_d && (o_boost_d == BW'(0));
		end
	end
endmodule

// >>> hdl/qport_pkg.sv
// Purpose: Constants shared by the quasi-bidirectional port pair
// Assumes: One core clock, synchronous active-low reset
// Notes: Pulse width of the strong high driver is a fixed cycle count
package qport_pkg;
	localparam int PORT_W = 8;
	localparam logic [7:0] LATCH_RST = 8'hFF;
	// Strong high driver time, in ns, and its cycle count at 25 MHz
	localparam int BOOST_NS = 40;
	localparam int CLK_NS = 40;
	localparam int BOOST_CYC = (BOOST_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [1:0] BOOST_LOAD = 2'(BOOST_CYC);
	localparam int MEM_CE_LO = 0;
	localparam int MEM_ADDR_LO = 4;
	localparam int CAN0_TX_BIT = 0;
	localparam int CAN0_RX_BIT = 1;
	localparam int CAN1_RX_BIT = 2;
	localparam int CAN1_TX_BIT = 3;
	localparam int PCE_LO = 4;
	localparam int PCE_N = 4;
	localparam int MEM_CE_N = 4;
	localparam int MEM_ADDR_N = 4;
	localparam int BOOST_W = 2;
endpackage

// >>> sim/qport_sva.sv
// Purpose: Timing and pin mapping checks for the port pair
// Assumes: Ports of quasi_bidir_port_pair, one clock
// Notes: Attached by bind below
`timescale 1ns/1ns
module qport_sva (
	input wire logic i_clk_sys, i_rst_n, i_mem_wr, i_can_enable, i_serial1_pin_relocate,
	input wire logic i_can_first_transmit, i_can_second_transmit, i_serial_second_transmit,
	input wire logic [7:0] i_mem_wr_data, i_mem_port_function_config, i_mem_pin, i_can_pin,
	input wire logic [3:0] i_prog_chip_enable, i_upper_addr, i_periph_enable_sel, i_periph_enable,
	input wire logic [7:0] o_mem_pin, o_mem_pin_oe_n, o_can_pin, o_can_pin_oe_n, o_mem_rd_data,
	input wire logic o_can_first_receive, o_serial_second_receive
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	sequence s_up;
		i_mem_wr && i_mem_wr_data[0] && !o_mem_pin[0] && !$past(i_mem_port_function_config[0])
			&& !i_mem_port_function_config[0];
	endsequence
	sequence s_idle;
		!i_mem_wr && !i_mem_port_function_config[0];
	endsequence
	property p_rst;
		disable iff (1'b0) !i_rst_n |=> &{o_mem_pin, o_mem_pin_oe_n, o_can_pin_oe_n};
	endproperty
	a_rst: assert property (p_rst) else $error("reset state wrong");
	property p_lat;
		i_mem_wr && i_mem_port_function_config == 8'h00 |=> o_mem_pin == $past(i_mem_wr_data);
	endproperty
	a_lat: assert property (p_lat) else $error("latch not shown");
	property p_bst;
		s_up ##1 s_idle |-> !o_mem_pin_oe_n[0] && o_mem_pin[0] ##1 o_mem_pin_oe_n[0];
	endproperty
	a_bst: assert property (p_bst) else $error("boost pulse wrong");
	property p_mem;
		i_mem_port_function_config == 8'hFF |=> o_mem_pin_oe_n == 8'h00
			&& o_mem_pin == {$past(i_upper_addr), $past(i_prog_chip_enable)};
	endproperty
	a_mem: assert property (p_mem) else $error("memory pins wrong");
	property p_can;
		i_can_enable && !i_serial1_pin_relocate |=> o_can_pin[0] == $past(i_can_first_transmit)
			&& o_can_pin[3] == $past(i_can_second_transmit);
	endproperty
	a_can: assert property (p_can) else $error("can transmit wrong");
	property p_ser;
		i_serial1_pin_relocate |=> !o_can_pin_oe_n[3] && o_can_pin[3] == $past(i_serial_second_transmit);
	endproperty
	a_ser: assert property (p_ser) else $error("serial pin wrong");
	property p_pce;
		i_periph_enable_sel == 4'hF |=> o_can_pin[7:4] == $past(i_periph_enable);
	endproperty
	a_pce: assert property (p_pce) else $error("peripheral enable wrong");
	property p_rx;
		$past(i_rst_n) |-> o_can_first_receive == $past(i_can_pin[1])
			&& o_serial_second_receive == $past(i_can_pin[2]) && o_mem_rd_data == $past(i_mem_pin);
	endproperty
	a_rx: assert property (p_rx) else $error("pin level not reported");
endmodule
bind quasi_bidir_port_pair qport_sva chk_u (.*);

// >>> sim/qport_far.sv
// Purpose: Far-side devices on one port
// Assumes: Strong drive from the port wins
// Notes: Sink mask comes from the bench
`timescale 1ns/1ns
module qport_far (
	input wire logic [7:0] i_pin,
	input wire logic [7:0] i_oe_n,
	input wire logic [7:0] i_pull_lo,
	output logic [7:0] o_lvl
);
	// Released pins sit at the pullup unless a device sinks them
	assign o_lvl = (~i_oe_n & i_pin) | (i_oe_n & ~i_pull_lo);
endmodule

// >>> sim/test_quasi_bidir_port_pair.sv
// Purpose: Random and corner checks of the port pair
// Assumes: Inputs driven on the falling edge
// Notes: Latch and boost expectations kept in bench variables
`timescale 1ns/1ns
module test_quasi_bidir_port_pair;
	logic clk = 0, rst_n = 0, mw = 0, cw = 0, cen = 0, rel = 0, t0 = 0, t1 = 0, st = 0;
	logic [7:0] md = 0, cd = 0, cfg = 0, mo, moe, co, coe, mpl = 0, cpl = 0, ml, cl, ml_q, cl_q;
	logic [3:0] ce = 0, ad = 0, sel = 0, pe = 0;
	logic [7:0] eoe, ecoe, mrd, crd, lm, lc;
	logic r0, r1, rs;
	integer error_cnt = 0, checks_done = 0, seed = 32'h1ed5eab4;
	quasi_bidir_port_pair dut_u (.i_clk_sys(clk), .i_rst_n(rst_n), .i_mem_wr_data(md), .i_mem_wr(mw),
		.i_can_wr_data(cd), .i_can_wr(cw), .i_mem_port_function_config(cfg), .i_prog_chip_enable(ce),
		.i_upper_addr(ad), .i_can_enable(cen), .i_can_first_transmit(t0), .i_can_second_transmit(t1),
		.i_serial1_pin_relocate(rel), .i_serial_second_transmit(st), .i_periph_enable_sel(sel),
		.i_periph_enable(pe), .i_mem_pin(ml), .i_can_pin(cl), .o_mem_pin(mo), .o_mem_pin_oe_n(moe),
		.o_can_pin(co), .o_can_pin_oe_n(coe), .o_mem_rd_data(mrd), .o_can_rd_data(crd),
		.o_can_first_receive(r0), .o_can_second_receive(r1), .o_serial_second_receive(rs));
	qport_far far_m (.i_pin(mo), .i_oe_n(moe), .i_pull_lo(mpl), .o_lvl(ml));
	qport_far far_c (.i_pin(co), .i_oe_n(coe), .i_pull_lo(cpl), .o_lvl(cl));
	function automatic logic [7:0] can_alt(input logic [7:0] lat, input logic [3:0] s, p,
		input logic en, r, a, b, t);
		return {(s & p) | (~s & lat[7:4]), r ? t : (en ? b : lat[3]), lat[2:1], en ? a : lat[0]};
	endfunction
	task automatic chk(input logic [7:0] got, exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic close_out;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		forever #20 clk = ~clk;
	end
	initial begin
		repeat (12) @(negedge clk);
		rst_n = 1;
		chk(moe & coe & mo, 8'hFF);
		ml_q = 8'hFF;
		cl_q = 8'hFF;
		for (int i = 0; i < 60; i++) begin
			mw = (i < 2) | $random(seed);
			cw = $random(seed);
			md = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : $random(seed);
			{cd, mpl, cpl} = $random(seed);
			eoe = mw ? (ml_q & md) : ml_q;
			ecoe = cw ? (cl_q & cd) : cl_q;
			ml_q = mw ? md : ml_q;
			cl_q = cw ? cd : cl_q;
			#1;
			lm = ml;
			lc = cl;
			@(negedge clk);
			chk(mrd, lm);
			chk(crd, lc);
			chk({5'h00, r0, r1, rs}, {5'h00, lc[1], lc[2], lc[2]});
			chk(mo, ml_q);
			chk(moe, eoe);
			chk(co, cl_q);
			chk(coe, ecoe);
		end
		$display("gpio test done");
		{mw, cw} = 2'h0;
		for (int i = 0; i < 40; i++) begin
			{cfg, ce, ad} = $random(seed);
			{cen, rel, t0, t1, st, sel, pe} = $random(seed);
			if (i == 0) begin
				cfg = 8'hFF;
				sel = 4'hF;
			end
			@(negedge clk);
			chk(mo, (cfg & {ad, ce}) | (~cfg & ml_q));
			chk(moe, ~cfg & ml_q);
			chk(co, can_alt(cl_q, sel, pe, cen, rel, t0, t1, st));
			chk(coe, cl_q & ~{sel, cen | rel, 2'h0, cen});
		end
		$display("alternate test done");
		rst_n = 0;
		@(negedge clk);
		rst_n = 1;
		chk(moe & coe & mo, 8'hFF);
		close_out();
	end
endmodule
